// [pkg/analog_monitor_consts.svh]
`ifndef ANALOG_MONITOR_CONSTS_SVH
`define ANALOG_MONITOR_CONSTS_SVH

// ==========================================================
// register addresses on the peripheral bus
`define AM_ADDR_W             24
`define AM_CTRL_STATUS_ADDR   24'h00fd40
`define AM_CONFIG_ADDR        24'h00fd42

// ==========================================================
// control/status field positions
`define AM_START_BIT          0
`define AM_MEAS_DONE_BIT      1
`define AM_CMP_DONE_BIT       2
`define AM_CROSS_BIT          3
`define AM_NUM_FLAGS          3

// ==========================================================
// configuration field positions
`define AM_MODE_LSB           0
`define AM_MODE_MSB           1
`define AM_MEAS_IRQ_EN_BIT    3
`define AM_CROSS_IRQ_EN_BIT   4
`define AM_DIRECTION_BIT      5

// ==========================================================
// reset values and writable masks
`define AM_CTRL_STATUS_RESET  8'h00
`define AM_CONFIG_RESET       8'h00
`define AM_CONFIG_WMASK       8'h3b
`define AM_FLAG_RESET         3'h0

`endif

// [pkg/analog_monitor_pkg.sv]
`default_nettype none

package analog_monitor_pkg;

   // ==========================================================
   // operating modes, in mode-select code order 00..11
   typedef enum logic [1:0] {
      MODE_DISABLED,
      MODE_VOLT_BURST,
      MODE_CMP_BURST,
      MODE_LOWPOWER_CMP
   } mode_e;

   typedef logic [7:0] reg_byte_t;

endpackage : analog_monitor_pkg

`default_nettype wire

// [pkg/monitor_event_if.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// event flag carrier between the control block and the flag bank
interface monitor_event_if;
   logic [2:0] set_pulse;   // hardware events, already gated by mode
   logic [2:0] clear_w1c;   // software write-one-to-clear
   logic       clear_all;   // effective start clears every flag
   logic [2:0] flag_q;      // current sticky flags

   modport control_side (output set_pulse, output clear_w1c, output clear_all, input flag_q);
   modport flags_side   (input set_pulse, input clear_w1c, input clear_all, output flag_q);
endinterface : monitor_event_if

`default_nettype wire

// [rtl/monitor_event_flags.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// sticky event flags, one per event
module monitor_event_flags (
   input wire logic               clk_i,   // core clock
   input wire logic               srst_i,  // synchronous reset, high
   monitor_event_if.flags_side    ev       // flag controls and state
);

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_flag
         logic flag_d;
         logic flag_q;

         // a set in the same cycle as any clear wins, so no event is lost
         always_comb begin
            if (ev.set_pulse[g]) begin
               flag_d = 1'b1;
            end else if (ev.clear_w1c[g] || ev.clear_all) begin
               flag_d = 1'b0;
            end else begin
               flag_d = flag_q;
            end
         end

         // register only
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               flag_q <= 1'b0;
            end else begin
               flag_q <= flag_d;
            end
         end

         assign ev.flag_q[g] = flag_q;
      end
   endgenerate

endmodule : monitor_event_flags

`default_nettype wire

// [rtl/analog_monitor_control_status.sv]
`timescale 1ns/1ps
`default_nettype none
`include "analog_monitor_consts.svh"

module analog_monitor_control_status
   import analog_monitor_pkg::*;
#(
   parameter int ADDR_W = `AM_ADDR_W     // peripheral bus address width
) (
   input  wire logic              CLK_SYS_I,        // core clock, 200 MHz
   input  wire logic              SRST_I,           // synchronous reset, high
   input  wire logic [ADDR_W-1:0] ADDR_I,           // register byte address
   input  wire logic              WR_I,             // write strobe, one cycle
   input  wire logic              RD_I,             // read strobe, one cycle
   input  wire logic [7:0]        WDATA_I,          // write data
   output var  logic [7:0]        RDATA_O,          // read data, cycle after RD_I
   input  wire logic              MEAS_BURST_DONE_I,// datapath: voltage burst done
   input  wire logic              CMP_BURST_DONE_I, // datapath: compare burst done
   input  wire logic              LP_CMP_VALID_I,   // datapath: periodic compare done
   input  wire logic              ANY_BELOW_I,      // some input below threshold
   input  wire logic              ANY_ABOVE_I,      // some input above threshold
   output var  logic [1:0]        ACTIVE_MODE_O,    // mode in use by datapath
   output var  logic              START_O,          // pulse: new mode begins
   output var  logic              DIRECTION_O,      // direction select to datapath
   output var  logic              MONITOR_INTERRUPT_O // to controller and wake-up unit
);

   // ==========================================================
   // elaboration check
   if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 16 and 32");
   end

   // ==========================================================
   // address decode, shared by the read and write paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [23:0]       target);
      logic [31:0] wide;
      wide = 32'(addr);
      return wide == 32'(target);
   endfunction

   // ==========================================================
   // declarations
   mode_e          active_mode_q;
   mode_e          active_mode_d;
   reg_byte_t      config_q;
   reg_byte_t      config_d;
   logic           start_q;
   logic           start_d;
   logic [7:0]     rdata_q;
   logic [7:0]     rdata_d;
   logic           irq_q;
   logic           irq_d;
   logic           cs_write;
   logic           cfg_write;
   logic           start_req;
   logic           start_eff;
   mode_e          cfg_mode;
   logic           meas_irq_en;
   logic           cross_irq_en;
   logic           direction;
   logic           crossing;
   logic [2:0]     set_pulse;
   logic [2:0]     clear_w1c;

   monitor_event_if ev ();

   // ==========================================================
   // configuration fields
   assign cfg_mode     = mode_e'(config_q[`AM_MODE_MSB:`AM_MODE_LSB]);
   assign meas_irq_en  = config_q[`AM_MEAS_IRQ_EN_BIT];
   assign cross_irq_en = config_q[`AM_CROSS_IRQ_EN_BIT];
   assign direction    = config_q[`AM_DIRECTION_BIT];

   // write decode
   assign cs_write  = WR_I && addr_hit(ADDR_I, `AM_CTRL_STATUS_ADDR);
   assign cfg_write = WR_I && addr_hit(ADDR_I, `AM_CONFIG_ADDR);

   // ==========================================================
   // start trigger: only a one counts, and only if the mode changes
   assign start_req = cs_write && WDATA_I[`AM_START_BIT];
   assign start_eff = start_req && (cfg_mode != active_mode_q);

   // ==========================================================
   // active mode follows the configuration only at an effective start
   always_comb begin
      active_mode_d = active_mode_q;
      start_d       = 1'b0;
      if (start_eff) begin
         active_mode_d = cfg_mode;
         start_d       = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         active_mode_q <= MODE_DISABLED;
         start_q       <= 1'b0;
      end else begin
         active_mode_q <= active_mode_d;
         start_q       <= start_d;
      end
   end

   // ==========================================================
   // configuration register; reserved bits never store
   always_comb begin
      config_d = config_q;
      if (cfg_write) begin
         config_d = WDATA_I & `AM_CONFIG_WMASK;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         config_q <= `AM_CONFIG_RESET;
      end else begin
         config_q <= config_d;
      end
   end

   // ==========================================================
   // event gating: each event only counts in its own active mode,
   // so a late done from an abandoned mode cannot set a flag
   assign crossing = direction ? ANY_ABOVE_I : ANY_BELOW_I;

   always_comb begin
      set_pulse = 3'h0;
      unique case (active_mode_q)
         MODE_DISABLED: begin
            set_pulse = 3'h0;
         end
         MODE_VOLT_BURST: begin
            set_pulse[0] = MEAS_BURST_DONE_I;
         end
         MODE_CMP_BURST: begin
            set_pulse[1] = CMP_BURST_DONE_I;
         end
         MODE_LOWPOWER_CMP: begin
            set_pulse[2] = LP_CMP_VALID_I && crossing;
         end
      endcase
   end

   // software write-one-to-clear on the flag bits
   assign clear_w1c = cs_write ? WDATA_I[`AM_CROSS_BIT:`AM_MEAS_DONE_BIT] : 3'h0;

   assign ev.set_pulse = set_pulse;
   assign ev.clear_w1c = clear_w1c;
   assign ev.clear_all = start_eff;

   monitor_event_flags u_flags (
      .clk_i  (CLK_SYS_I),
      .srst_i (SRST_I),
      .ev     (ev)
   );

   // ==========================================================
   // interrupt: level from flags and enables, one cycle behind the
   // flags because the output must come from a flip-flop
   always_comb begin
      irq_d = (ev.flag_q[0] && meas_irq_en)
           || (ev.flag_q[2] && cross_irq_en);
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ==========================================================
   // read path; start reads zero, unmapped addresses read zero
   always_comb begin
      rdata_d = 8'h00;
      if (RD_I) begin
         if (addr_hit(ADDR_I, `AM_CTRL_STATUS_ADDR)) begin
            rdata_d = {4'h0, ev.flag_q, 1'b0};
         end else if (addr_hit(ADDR_I, `AM_CONFIG_ADDR)) begin
            rdata_d = config_q;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   assign RDATA_O             = rdata_q;
   assign ACTIVE_MODE_O       = active_mode_q;
   assign START_O             = start_q;
   assign DIRECTION_O         = config_q[`AM_DIRECTION_BIT];
   assign MONITOR_INTERRUPT_O = irq_q;

endmodule : analog_monitor_control_status

`default_nettype wire

// [test/analog_monitor_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "analog_monitor_consts.svh"

// ==========================================================
// port-level checker for the monitor control block
module analog_monitor_chk
   import analog_monitor_pkg::*;
#(
   parameter int ADDR_W = 24  // bus address width
) (
   input wire logic              CLK_SYS_I,            // clock
   input wire logic              SRST_I,               // reset
   input wire logic [ADDR_W-1:0] ADDR_I,               // address
   input wire logic              WR_I,                 // write
   input wire logic              RD_I,                 // read
   input wire logic [7:0]        WDATA_I,              // wdata
   input wire logic [7:0]        RDATA_O,              // rdata
   input wire logic              MEAS_BURST_DONE_I,    // volt done
   input wire logic              CMP_BURST_DONE_I,     // cmp done
   input wire logic              LP_CMP_VALID_I,       // lp valid
   input wire logic              ANY_BELOW_I,          // below
   input wire logic              ANY_ABOVE_I,          // above
   input wire logic [1:0]        ACTIVE_MODE_O,        // mode
   input wire logic              START_O,              // start
   input wire logic              DIRECTION_O,          // direction
   input wire logic              MONITOR_INTERRUPT_O   // irq
);
   logic cs_w;
   logic cf_w;
   logic ev_w;
   // decoded writes and mode-gated events that may raise the request
   assign cs_w = WR_I && (ADDR_I == `AM_CTRL_STATUS_ADDR);
   assign cf_w = WR_I && (ADDR_I == `AM_CONFIG_ADDR);
   // a periodic result only counts when it lies on the selected side
   assign ev_w = (MEAS_BURST_DONE_I && ACTIVE_MODE_O == 2'h1)
              || (LP_CMP_VALID_I && ACTIVE_MODE_O == 2'h3
                  && (DIRECTION_O ? ANY_ABOVE_I : ANY_BELOW_I));

   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);

   // ==========================================================
   // start and mode
   start_pulse_a: assert property (START_O && !cs_w |=> !START_O)
      else $error("start pulse too long");
   start_cause_a: assert property (START_O |-> $past(cs_w && WDATA_I[0]))
      else $error("start without start write");
   start_mode_a: assert property (START_O |-> ACTIVE_MODE_O != $past(ACTIVE_MODE_O))
      else $error("start with unchanged mode");
   // a reset edge also zeroes the mode, so it is excused
   mode_hold_a: assert property ($changed(ACTIVE_MODE_O) |-> START_O || $past(SRST_I))
      else $error("mode changed without start");

   // ==========================================================
   // interrupt request
   irq_rise_a: assert property ($rose(MONITOR_INTERRUPT_O)
      |-> $past(ev_w, 2) || $past(cf_w, 2))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(MONITOR_INTERRUPT_O)
      |-> $past(WR_I, 2) || $past(SRST_I))
      else $error("interrupt fell without write");

   // ==========================================================
   // read data and direction
   rd_resv_a: assert property (RD_I && ADDR_I == `AM_CTRL_STATUS_ADDR
      |=> (RDATA_O & 8'hf1) == 8'h00)
      else $error("reserved or start bit read one");
   rd_unmap_a: assert property (RD_I && ADDR_I != `AM_CTRL_STATUS_ADDR
      && ADDR_I != `AM_CONFIG_ADDR |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   dir_follow_a: assert property ($changed(DIRECTION_O)
      |-> $past(cf_w) || $past(cf_w, 2) || $past(SRST_I))
      else $error("direction changed without write");

   cov_start: cover property (START_O);
   cov_irq: cover property ($rose(MONITOR_INTERRUPT_O));
   cov_cross: cover property (LP_CMP_VALID_I && ACTIVE_MODE_O == 2'h3);
endmodule // analog_monitor_chk

bind analog_monitor_control_status analog_monitor_chk #(.ADDR_W(ADDR_W)) i_chk (
   .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WR_I(WR_I),
   .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
   .MEAS_BURST_DONE_I(MEAS_BURST_DONE_I), .CMP_BURST_DONE_I(CMP_BURST_DONE_I),
   .LP_CMP_VALID_I(LP_CMP_VALID_I), .ANY_BELOW_I(ANY_BELOW_I),
   .ANY_ABOVE_I(ANY_ABOVE_I), .ACTIVE_MODE_O(ACTIVE_MODE_O), .START_O(START_O),
   .DIRECTION_O(DIRECTION_O), .MONITOR_INTERRUPT_O(MONITOR_INTERRUPT_O));

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "analog_monitor_consts.svh"

module testbench;
   import analog_monitor_pkg::*;
   localparam logic [23:0] CS = `AM_CTRL_STATUS_ADDR;
   localparam logic [23:0] CF = `AM_CONFIG_ADDR;
   logic        clk, rst, wr, rd, md, cd, lv, lo, hi, ps;
   logic [23:0] a;
   logic [7:0]  wd;
   logic [7:0]  rdt;
   logic [1:0]  am;
   logic        st, dir, irq;
   int          fail_count, check_count, cyc_n;

   analog_monitor_control_status i_analog_monitor_control_status (
      .CLK_SYS_I(clk), .SRST_I(rst), .ADDR_I(a), .WR_I(wr), .RD_I(rd),
      .WDATA_I(wd), .RDATA_O(rdt), .MEAS_BURST_DONE_I(md),
      .CMP_BURST_DONE_I(cd), .LP_CMP_VALID_I(lv), .ANY_BELOW_I(lo),
      .ANY_ABOVE_I(hi), .ACTIVE_MODE_O(am), .START_O(st),
      .DIRECTION_O(dir), .MONITOR_INTERRUPT_O(irq));

   // ==========================================================
   // clock, cycle ceiling and helpers
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   // the run needs about 110 cycles; far more means a hang
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // idle cycle after each strobe so no strobe is set twice in one step
   task automatic wrr(logic [23:0] ad, logic [7:0] d);
      a = ad;
      wd = d;
      wr = 1;
      tick(1);
      ps = st;
      wr = 0;
      tick(1);
   endtask
   task automatic rdc(logic [23:0] ad, logic [7:0] e, string n);
      a = ad;
      rd = 1;
      tick(1);
      rd = 0;
      chk(n, rdt, e);
      tick(1);
   endtask
   task automatic pulse(logic m, logic c, logic l);
      {md, cd, lv} = {m, c, l};
      tick(1);
      {md, cd, lv} = 3'h0;
      tick(2);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      rdc(CS, 8'h00, "cts reset");
      rdc(CF, 8'h00, "cnf reset");
      wrr(24'h00fd41, 8'hff);
      rdc(24'h00fd41, 8'h00, "unmapped");
      wrr(CF, 8'hff);
      rdc(CF, 8'h3b, "cnf mask");
      chk("dir", dir, 1);
      chk("mode no start", am, 0);
      wrr(CF, 8'h00);
   endtask
   task automatic t_meas();
      wrr(CF, 8'h09);
      wrr(CS, 8'h01);
      chk("start", ps, 1);
      chk("start clr", st, 0);
      chk("mode", am, 1);
      // both sides active, so a leak of the periodic event would show
      {lo, hi} = 2'b11;
      pulse(0, 1, 1);
      rdc(CS, 8'h00, "wrong mode");
      pulse(1, 0, 0);
      chk("irq", irq, 1);
      rdc(CS, 8'h02, "meas flag");
      wrr(CS, 8'h01);
      chk("same start", ps, 0);
      rdc(CS, 8'h02, "kept");
      wrr(CS, 8'h00);
      chk("zero start", ps, 0);
      wrr(CF, 8'h01);
      chk("irq masked", irq, 0);
      wrr(CF, 8'h09);
      chk("irq back", irq, 1);
      wrr(CS, 8'h02);
      chk("irq w1c", irq, 0);
      rdc(CS, 8'h00, "w1c");
   endtask
   task automatic t_cmp();
      pulse(1, 0, 0);
      wrr(CF, 8'h0a);
      wrr(CS, 8'h01);
      chk("mode", am, 2);
      rdc(CS, 8'h00, "start clears");
      pulse(1, 1, 0);
      rdc(CS, 8'h04, "cmp flag");
      chk("no cmp irq", irq, 0);
      wrr(CS, 8'h04);
      rdc(CS, 8'h00, "cmp w1c");
   endtask
   task automatic t_cross();
      for (int d = 0; d < 2; d++) begin
         wrr(CF, d ? 8'h33 : 8'h13);
         if (d == 0)
            wrr(CS, 8'h01);
         chk("mode", am, 3);
         chk("dir", dir, d[0]);
         {lo, hi} = {d[0], !d[0]};
         pulse(0, 0, 1);
         rdc(CS, 8'h00, "other side");
         {lo, hi} = {!d[0], d[0]};
         pulse(0, 0, 1);
         rdc(CS, 8'h08, "cross");
         chk("cross irq", irq, 1);
         wrr(CS, 8'h08);
         chk("cross w1c", irq, 0);
      end
      pulse(0, 0, 1);
      wrr(CF, 8'h23);
      chk("cross masked", irq, 0);
      wrr(CF, 8'h00);
      chk("no start", am, 3);
      wrr(CS, 8'h01);
      chk("off", am, 0);
      rdc(CS, 8'h00, "off clears");
   endtask

   initial begin
      {wr, rd, md, cd, lv, lo, hi, ps} = 8'h00;
      a = 24'h000000;
      wd = 8'h00;
      rst = 1;
      tick(10);
      rst = 0;
      t_regs();
      t_meas();
      t_cmp();
      t_cross();
      close_out();
   end
endmodule // testbench

`default_nettype wire
